// >>> hdl/clm_control_lines.sv
`timescale 1ns/1ps
`include "clm_regs.svh"

// Notes on behaviour
// - sixteen output bits held until rewritten
// - register half cleared before new byte loads
// - command strobe clears all sixteen outputs
// - compare data lines against strapped address
// - address defaults to 71, straps alter it
// - each strap inverts one default address bit
// - strobe plus match sets selected flag
// - every selected data strobe returns sync pulse, unless a command or initialize edge comes in the same cycle
// - steering toggles on trailing edge of strobe
// - steering clear: first gate loads lines 0-7
// - steering set: second gate loads lines 8-15
// - active low data line grounds its output
// - initialize clears selection, steering, outputs
// - command strobe resets steering to first byte
// - no readable status byte exists
module clm_control_lines
   import clm_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // processor bus strobes, asynchronous
   input  wire logic        address_strobe_n,
   input  wire logic        data_avail_strobe,
   input  wire logic        command_strobe_n,
   input  wire logic        initialize_pulse_n,
   // processor data lines, active low, asynchronous
   input  wire logic [7:0]  proc_data_line_n,
   // address straps, a one inverts that default address bit
   input  wire logic [7:0]  address_strap,
   // acknowledge back to the processor
   output logic             sync_acknowledge,
   // byte gate pulses and selection flag, visible for debug
   output logic             first_byte_gate,
   output logic             second_byte_gate,
   output logic             module_selected,
   // open-collector control lines: oe high grounds the line
   output logic [15:0]      control_out_line_o,
   output logic [15:0]      control_out_line_oe
);

   // synchroniser stages; stage one is read only by stage two
   clm_strobe_vec_t         stb_meta;
   clm_strobe_vec_t         stb_sync;
   clm_strobe_vec_t         stb_last;
   logic [7:0]              data_meta;
   logic [7:0]              data_sync;
   logic [7:0]              strap_meta;
   logic [7:0]              strap_sync;

   // edge events and state
   logic                    addr_fall;
   logic                    data_lead;
   logic                    data_trail;
   logic                    cmd_fall;
   logic                    init_fall;
   logic                    address_match_high;
   logic [7:0]              device_address;
   logic                    module_selected_flag;
   logic                    data_busy;
   clm_steer_t              steer;
   logic [15:0]             control_reg;
   logic                    qual_data;
   logic                    load_first;
   logic                    load_second;
   logic [7:0]              load_byte;

   // active-high strobe picture; data strobe is already high-true
   clm_strobe_vec_t         stb_raw;
   assign stb_raw = {~initialize_pulse_n, ~command_strobe_n,
                     data_avail_strobe, ~address_strobe_n};

   // two-flop synchronisers for every asynchronous input
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         stb_meta   <= `CLM_STB_IDLE;
         stb_sync   <= `CLM_STB_IDLE;
         stb_last   <= `CLM_STB_IDLE;
         data_meta  <= `CLM_BYTE_ZERO;
         data_sync  <= `CLM_BYTE_ZERO;
         strap_meta <= `CLM_BYTE_ZERO;
         strap_sync <= `CLM_BYTE_ZERO;
      end
      else
      begin
         stb_meta   <= stb_raw;
         stb_sync   <= stb_meta;
         stb_last   <= stb_sync;
         data_meta  <= ~proc_data_line_n; // bus is low-true
         data_sync  <= data_meta;
         strap_meta <= address_strap;
         strap_sync <= strap_meta;
      end
   end

   // one-cycle events from the synchronised strobes
   assign addr_fall  = stb_sync[`CLM_STB_ADDR] &
                       ~stb_last[`CLM_STB_ADDR];
   assign data_lead  = stb_sync[`CLM_STB_DATA] &
                       ~stb_last[`CLM_STB_DATA];
   assign data_trail = ~stb_sync[`CLM_STB_DATA] &
                       stb_last[`CLM_STB_DATA];
   assign cmd_fall   = stb_sync[`CLM_STB_CMD] &
                       ~stb_last[`CLM_STB_CMD];
   assign init_fall  = stb_sync[`CLM_STB_INIT] &
                       ~stb_last[`CLM_STB_INIT];

   // straps flip default bits, so an empty strap board gives 71
   assign device_address = `CLM_DEFAULT_ADDR ^ strap_sync;
   // full eight-bit match only; partial matches never select
   assign address_match_high = (data_sync == device_address);

   // selection flag; initialize wins over any address strobe
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         module_selected_flag <= 1'b0;
      else if (init_fall)
         module_selected_flag <= 1'b0;
      else if (addr_fall)
         module_selected_flag <= address_match_high;
   end
   assign module_selected = module_selected_flag;

   // data strobe counts only while selected and no clear is pending
   assign qual_data   = data_lead & module_selected_flag &
                        ~init_fall & ~cmd_fall;
   assign load_first  = qual_data & (steer == clm_steer_first);
   assign load_second = qual_data & (steer == clm_steer_second);
   assign load_byte   = data_sync;

   // remember a qualified strobe until its trailing edge
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         data_busy <= 1'b0;
      else if (init_fall || cmd_fall)
         data_busy <= 1'b0;
      else if (qual_data)
         data_busy <= 1'b1;
      else if (data_trail)
         data_busy <= 1'b0;
   end

   // steering moves only at the trailing edge, so the gate of the
   // same strobe still sees the old half
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         steer <= clm_steer_first;
      else if (init_fall || cmd_fall)
         steer <= clm_steer_first;
      else if (data_trail && data_busy)
      begin
         if (steer == clm_steer_first)
            steer <= clm_steer_second;
         else
            steer <= clm_steer_first;
      end
   end

   // acknowledge and byte gates, one clock each
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         sync_acknowledge <= 1'b0;
         first_byte_gate  <= 1'b0;
         second_byte_gate <= 1'b0;
      end
      else
      begin
         sync_acknowledge <= qual_data;
         first_byte_gate  <= load_first;
         second_byte_gate <= load_second;
      end
   end

   // output storage; each half is overwritten whole, which is the
   // clear-then-load of the original flip-flops in one step
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         control_reg <= `CLM_REG_RESET;
      else if (init_fall || cmd_fall)
         control_reg <= `CLM_REG_RESET;
      else if (load_first)
         control_reg[`CLM_LOW_MSB:`CLM_LOW_LSB] <= load_byte;
      else if (load_second)
         control_reg[`CLM_HIGH_MSB:`CLM_HIGH_LSB] <= load_byte;
   end

   // a one in the register turns the line's transistor on
   assign control_out_line_o  = `CLM_REG_RESET;
   assign control_out_line_oe = control_reg;
   // nothing here is readable by the processor

   property p_ack_on_data;
      @(posedge clock) disable iff (sys_rst)
      qual_data |=> sync_acknowledge ##1 !sync_acknowledge;
   endproperty
   a_ack_on_data: assert property (p_ack_on_data)
      else $error("no single sync pulse for a selected strobe");

   property p_no_ack_idle;
      @(posedge clock) disable iff (sys_rst)
      data_lead && !module_selected_flag |=> !sync_acknowledge;
   endproperty
   a_no_ack_idle: assert property (p_no_ack_idle)
      else $error("sync returned while not selected");

   property p_first_load;
      @(posedge clock) disable iff (sys_rst)
      first_byte_gate |-> !second_byte_gate &&
         control_reg[`CLM_LOW_MSB:`CLM_LOW_LSB] == $past(data_sync);
   endproperty
   a_first_load: assert property (p_first_load)
      else $error("first byte gate did not load low half");

   property p_second_load;
      @(posedge clock) disable iff (sys_rst)
      second_byte_gate |-> !first_byte_gate &&
         control_reg[`CLM_HIGH_MSB:`CLM_HIGH_LSB] == $past(data_sync);
   endproperty
   a_second_load: assert property (p_second_load)
      else $error("second byte gate did not load high half");

   property p_cmd_clear;
      @(posedge clock) disable iff (sys_rst)
      cmd_fall |=> control_reg == `CLM_REG_RESET &&
         steer == clm_steer_first;
   endproperty
   a_cmd_clear: assert property (p_cmd_clear)
      else $error("command strobe did not clear outputs");

   property p_init_clear;
      @(posedge clock) disable iff (sys_rst)
      init_fall |=> control_reg == `CLM_REG_RESET && !module_selected_flag
         && steer == clm_steer_first;
   endproperty
   a_init_clear: assert property (p_init_clear)
      else $error("initialize did not clear state");

   property p_hold;
      @(posedge clock) disable iff (sys_rst)
      !load_first && !load_second && !cmd_fall && !init_fall
         |=> $stable(control_out_line_oe);
   endproperty
   a_hold: assert property (p_hold)
      else $error("outputs changed without a write");

   property p_select;
      @(posedge clock) disable iff (sys_rst)
      addr_fall && !init_fall |=>
         module_selected_flag == $past(address_match_high);
   endproperty
   a_select: assert property (p_select)
      else $error("selection does not follow address match");

   property p_steer_trail;
      @(posedge clock) disable iff (sys_rst)
      data_trail && data_busy && !cmd_fall && !init_fall
         |=> steer != $past(steer);
   endproperty
   a_steer_trail: assert property (p_steer_trail)
      else $error("steering did not toggle at trailing edge");

   property p_steer_lead;
      @(posedge clock) disable iff (sys_rst)
      qual_data |=> $stable(steer);
   endproperty
   a_steer_lead: assert property (p_steer_lead)
      else $error("steering moved at the leading edge");

   // every sync pulse pairs with exactly one byte gate
   property p_gate_ack;
      @(posedge clock) disable iff (sys_rst)
      sync_acknowledge |-> first_byte_gate ^ second_byte_gate;
   endproperty
   a_gate_ack: assert property (p_gate_ack)
      else $error("sync pulse without a single byte gate");

   // a strobe for another device must not load or steer
   property p_no_load_idle;
      @(posedge clock) disable iff (sys_rst)
      data_lead && !module_selected_flag |=> !first_byte_gate &&
         !second_byte_gate && $stable(steer);
   endproperty
   a_no_load_idle: assert property (p_no_load_idle)
      else $error("unselected strobe loaded or steered");

   c_two_writes: cover property (@(posedge clock) disable iff (sys_rst)
      first_byte_gate ##[1:200] second_byte_gate);
   c_cmd_after_first: cover property (@(posedge clock)
      disable iff (sys_rst) first_byte_gate ##[1:200] cmd_fall);
   c_deselect: cover property (@(posedge clock) disable iff (sys_rst)
      module_selected_flag ##1 !module_selected_flag);
   c_strap_select: cover property (@(posedge clock) disable iff (sys_rst)
      (strap_sync != `CLM_BYTE_ZERO) && addr_fall && address_match_high);

endmodule : clm_control_lines

// >>> hdl/clm_regs.svh
`ifndef CLM_REGS_SVH
`define CLM_REGS_SVH

// device address with no straps fitted
`define CLM_DEFAULT_ADDR   8'h71
// width of the processor data bus
`define CLM_BYTE_W         8
// number of control lines
`define CLM_LINES_W        16
// bit ranges of the two halves of the output register
`define CLM_LOW_MSB        7
`define CLM_LOW_LSB        0
`define CLM_HIGH_MSB       15
`define CLM_HIGH_LSB       8
// strobe vector positions after synchronisation
`define CLM_STB_ADDR       0
`define CLM_STB_DATA       1
`define CLM_STB_CMD        2
`define CLM_STB_INIT       3
`define CLM_STB_W          4
// reset values
`define CLM_REG_RESET      16'h0000
`define CLM_BYTE_ZERO      8'h00
`define CLM_STB_IDLE       4'h0

`endif

// >>> hdl/clm_pkg.sv
package clm_pkg;

   // which half of the register the next data strobe loads
   typedef enum logic
   {
      clm_steer_first,
      clm_steer_second
   } clm_steer_t;

   // strobe picture after the synchroniser, one bit per strobe
   typedef logic [3:0] clm_strobe_vec_t;

endpackage : clm_pkg

// >>> sim/clm_proc_model.sv
`timescale 1ns/1ps

module clm_proc_model
(
   // clock and device answers
   input  wire logic       clock,
   input  wire logic       sync_acknowledge,
   input  wire logic       first_byte_gate,
   input  wire logic       second_byte_gate,
   // strobes and data lines towards the device
   output logic            address_strobe_n,
   output logic            data_avail_strobe,
   output logic            command_strobe_n,
   output logic            initialize_pulse_n,
   output logic [7:0]      proc_data_line_n
);
   int ack_cnt = 0;
   int gate1_cnt = 0;
   int gate2_cnt = 0;

   // idle bus at time zero; lines show a pattern, not a stale value
   initial
   begin
      address_strobe_n = 1'b1;
      data_avail_strobe = 1'b0;
      command_strobe_n = 1'b1;
      initialize_pulse_n = 1'b1;
      proc_data_line_n = 8'h5a;
   end

   // tally of the one-cycle answers
   always @(posedge clock)
   begin
      if (sync_acknowledge === 1'b1) ack_cnt++;
      if (first_byte_gate === 1'b1) gate1_cnt++;
      if (second_byte_gate === 1'b1) gate2_cnt++;
   end

   // kind 0 address, 1 data, 2 command, 3 initialize
   task automatic set_stb(input int kind, input logic on);
      case (kind)
         0: address_strobe_n = !on;
         1: data_avail_strobe = on;
         2: command_strobe_n = !on;
         default: initialize_pulse_n = !on;
      endcase
   endtask : set_stb

   // data set up three cycles early and held past strobe release,
   // since the device samples lines through its synchroniser
   task automatic strobe(input int kind, input logic [7:0] value);
      @(posedge clock);
      #1 proc_data_line_n = ~value;
      repeat (3) @(posedge clock);
      #1 set_stb(kind, 1'b1);
      repeat (6) @(posedge clock);
      #1 set_stb(kind, 1'b0);
      repeat (3) @(posedge clock);
      #1 proc_data_line_n = value; // released: inverse of last value
   endtask : strobe
endmodule : clm_proc_model

// >>> sim/tb.sv
`timescale 1ns/1ps

module tb
   import clm_pkg::*;
;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  address_strap = 8'h00;
   logic        ast_n, das, cmd_n, ini_n, ack, g1, g2, sel;
   logic [7:0]  dl_n;
   logic [15:0] line_o, oe;
   int          failures = 0;
   int          comparisons = 0;

   // 125 MHz clock
   always #4 clock = ~clock;

   // device and processor model
   clm_control_lines dut (.clock(clock), .sys_rst(sys_rst),
      .address_strobe_n(ast_n), .data_avail_strobe(das),
      .command_strobe_n(cmd_n), .initialize_pulse_n(ini_n),
      .proc_data_line_n(dl_n), .address_strap(address_strap),
      .sync_acknowledge(ack), .first_byte_gate(g1),
      .second_byte_gate(g2), .module_selected(sel),
      .control_out_line_o(line_o), .control_out_line_oe(oe));
   clm_proc_model proc (.clock(clock), .sync_acknowledge(ack),
      .first_byte_gate(g1), .second_byte_gate(g2),
      .address_strobe_n(ast_n), .data_avail_strobe(das),
      .command_strobe_n(cmd_n), .initialize_pulse_n(ini_n),
      .proc_data_line_n(dl_n));

   task automatic check(input logic [15:0] seen, exp, input string m);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : check

   task automatic end_sim;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim

   task automatic t_reset;
      check(oe, 16'h0000, "oe after reset");
      check({15'h0000, sel}, 16'h0000, "sel after reset");
      check(line_o, 16'h0000, "pull-down value");
      $display("test reset done");
   endtask : t_reset

   // select, two writes, hold, then a full overwrite
   task automatic t_write;
      int a0;
      a0 = proc.ack_cnt;
      proc.strobe(0, 8'h71);
      check({15'h0000, sel}, 16'h0001, "select");
      proc.strobe(1, 8'ha5);
      check(oe, 16'h00a5, "low byte");
      proc.strobe(1, 8'h3c);
      check(oe, 16'h3ca5, "high byte");
      check(16'(proc.ack_cnt - a0), 16'h0002, "acks");
      check(16'(proc.gate1_cnt), 16'h0001, "gate one");
      check(16'(proc.gate2_cnt), 16'h0001, "gate two");
      repeat (20) @(posedge clock);
      check(oe, 16'h3ca5, "hold");
      proc.strobe(1, 8'h50);
      proc.strobe(1, 8'h00);
      check(oe, 16'h0050, "overwrite");
      $display("test write done");
   endtask : t_write

   task automatic t_deselect;
      int a0;
      a0 = proc.ack_cnt;
      proc.strobe(0, 8'h72);
      check({15'h0000, sel}, 16'h0000, "deselect");
      proc.strobe(1, 8'hff);
      check(oe, 16'h0050, "ignored write");
      check(16'(proc.ack_cnt - a0), 16'h0000, "no ack");
      $display("test deselect done");
   endtask : t_deselect

   // strap table: strap levels and the address they give
   task automatic t_straps;
      logic [7:0] st [3] = '{8'h3d, 8'h5a, 8'h8e};
      logic [7:0] ad [3] = '{8'h4c, 8'h2b, 8'hff};
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clock);
         #1 address_strap = st[i];
         proc.strobe(0, ad[i]);
         check({15'h0000, sel}, 16'h0001, "strap match");
         proc.strobe(0, ad[i] ^ 8'h01);
         check({15'h0000, sel}, 16'h0000, "strap miss");
      end
      @(posedge clock);
      #1 address_strap = 8'h00;
      proc.strobe(0, 8'h71);
      $display("test straps done");
   endtask : t_straps

   // command after a lone write must clear and reset steering
   task automatic t_command;
      proc.strobe(1, 8'h11);
      check(oe, 16'h0011, "lone write");
      proc.strobe(2, 8'h00);
      check(oe, 16'h0000, "command clear");
      check({15'h0000, sel}, 16'h0001, "selection kept");
      proc.strobe(1, 8'h22);
      check(oe, 16'h0022, "first after command");
      $display("test command done");
   endtask : t_command

   task automatic t_init;
      proc.strobe(3, 8'h00);
      check(oe, 16'h0000, "init clear");
      check({15'h0000, sel}, 16'h0000, "init deselect");
      proc.strobe(0, 8'h71);
      proc.strobe(1, 8'h44);
      check(oe, 16'h0044, "first after init");
      $display("test init done");
   endtask : t_init

   // main sequence
   initial
   begin
      repeat (5) @(posedge clock);
      #1 sys_rst = 1'b0;
      t_reset;
      t_write;
      t_deselect;
      t_straps;
      t_command;
      t_init;
      end_sim;
   end

   // watchdog: run needs well under 1000 cycles
   initial
   begin
      repeat (5000) @(posedge clock);
      failures++;
      $display("unexpected at %0t: watchdog", $time);
      end_sim;
   end
endmodule : tb
